// ---- src/usp_clk_gen.sv ----
// Half-period tick source for the master serial clock.
// Assumes sub_clk and tmr_match are synchronous to pclk.
`timescale 1ns/100ps
module usp_clk_gen import usp_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [2:0] sel,
  input wire logic sub_clk,
  input wire logic tmr_match,
  output logic tick
);
  logic [5:0] cnt_q;
  logic [5:0] half;
  logic sub_q;
  logic sub2_q;
  logic tick_q;

  // Divider half period by mode
  always_comb begin
    case (sel)
      USP_M_DIV4: half = HALF_A;
      USP_M_DIV16: half = HALF_B;
      default: half = HALF_C;
    endcase
  end

  // Sub clock history for edge spotting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sub_q <= 1'b0;
      sub2_q <= 1'b0;
    end else begin
      sub_q <= sub_clk;
      sub2_q <= sub_q;
    end
  end

  // Every tick is one serial clock half period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 6'h00;
      tick_q <= 1'b0;
    end else if (!run) begin
      cnt_q <= 6'h00;
      tick_q <= 1'b0;
    end else begin
      case (sel)
        USP_M_SUB: tick_q <= sub_q ^ sub2_q;
        USP_M_TMR: tick_q <= tmr_match;
        default: begin
          if (cnt_q == half - 6'h01) begin
            cnt_q <= 6'h00;
            tick_q <= 1'b1;
          end else begin
            cnt_q <= cnt_q + 6'h01;
            tick_q <= 1'b0;
          end
        end
      endcase
    end
  end

  assign tick = tick_q;
endmodule // usp_clk_gen

// ---- src/usp_edge.sv ----
// Level and edge detector for a pin input.
// Assumes the input is already synchronous to pclk.
`timescale 1ns/100ps
module usp_edge #(
  parameter logic RST = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic d,
  output logic lvl,
  output logic rise,
  output logic fall
);
  logic d_q;
  logic prev_q;

  // Two stages so edges are seen one cycle after the pin moves
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      d_q <= RST;
      prev_q <= RST;
    end else begin
      d_q <= d;
      prev_q <= d_q;
    end
  end

  assign lvl = d_q;
  assign rise = d_q & ~prev_q;
  assign fall = ~d_q & prev_q;
endmodule // usp_edge

// ---- src/usp_pkg.sv ----
// Constants, types and helpers for the SPI part of the shared serial unit.
// Assumes a single 25 MHz clock domain and 8-bit registers on 32-bit APB words.
// Function
// - Mode 000/001/010 is master, clock is system clock divided by 4/16/64.
// - Mode 011 clocks the master from sub clock; 100 from half the timer match rate.
// - Mode 101 is SPI slave; 110 is I2C slave; 111 is unused.
// - Mode field only counts when uart_select is 0; uart_select 1 means UART.
// - In slave mode the serial clock comes from the outside master.
// - The master starts every transfer and alone drives the serial clock.
// - interface_enable 0 frees data, clock and select lines; 1 enables the interface.
// - Turning interface_enable on keeps all control register contents unchanged.
// - select_pin_enable 1 enables the select pin; 0 leaves it floating.
// - Slave deselected early with both enables set raises incomplete and complete flags.
// - The early deselect raises the interrupt request when interrupts are enabled.
// - Software writing 1 to the incomplete flag never sets the complete flag.
// - Incomplete flag only means something in slave mode; debounce field only in I2C.
// - One shared 8-bit data register feeds transmit and receives the byte.
// - Format register exists only when SPI mode is selected; data register in SPI and I2C slave modes.
// - Polarity 1 idles clock low, 0 high; polarity xor edge picks capture edge.
// - shift_order 1 sends most significant bit first, 0 least significant first.
// - Data write during a transfer is dropped and sets the collision flag.
// - Master data write starts the transfer; completion sets a sticky complete flag.
package usp_pkg;
  localparam int unsigned CLK_HZ = 25_000_000;
  // Register byte offsets
  localparam logic [7:0] USP_OFF_MODE = 8'h00;
  localparam logic [7:0] USP_OFF_FMT = 8'h04;
  localparam logic [7:0] USP_OFF_DATA = 8'h08;
  // Values after reset
  localparam logic [7:0] USP_MODE_RST = 8'hE0;
  localparam logic [7:0] USP_FMT_RST = 8'h00;
  localparam logic [7:0] USP_DATA_RST = 8'h00;
  localparam logic USP_SCK_RST = 1'b1;
  // serial_mode_control fields
  localparam int unsigned MODE_FIELD_LSB = 5;
  localparam int unsigned MODE_UART_BIT = 4;
  localparam int unsigned MODE_EN_BIT = 1;
  localparam int unsigned MODE_ICF_BIT = 0;
  // spi_format_control fields
  localparam int unsigned FMT_POL_BIT = 5;
  localparam int unsigned FMT_EDGE_BIT = 4;
  localparam int unsigned FMT_MSB_BIT = 3;
  localparam int unsigned FMT_SELECT_PIN_ENABLE_BIT = 2;
  localparam int unsigned FMT_WRITE_COLLISION_FLAG_BIT = 1;
  localparam int unsigned FMT_TRF_BIT = 0;
  // Master clock dividers and their half periods in pclk cycles
  localparam int unsigned DIV_A = 4;
  localparam int unsigned DIV_B = 16;
  localparam int unsigned DIV_C = 64;
  localparam logic [5:0] HALF_A = 6'(DIV_A / 2);
  localparam logic [5:0] HALF_B = 6'(DIV_B / 2);
  localparam logic [5:0] HALF_C = 6'(DIV_C / 2);
  // Bits per transfer and clock edges per transfer
  localparam logic [3:0] USP_BITS = 4'h8;
  localparam logic [4:0] USP_EDGES = 5'h10;

  typedef enum logic [2:0] {
    USP_M_DIV4 = 3'b000,
    USP_M_DIV16 = 3'b001,
    USP_M_DIV64 = 3'b010,
    USP_M_SUB = 3'b011,
    USP_M_TMR = 3'b100,
    USP_S_SPI = 3'b101,
    USP_S_I2C = 3'b110,
    USP_UNUSED = 3'b111
  } usp_mode_t;

  typedef enum logic [1:0] {
    USP_IDLE = 2'b00,
    USP_MXFER = 2'b01,
    USP_SXFER = 2'b10
  } usp_state_t;

  // SPI is selected when UART is off and the field names an SPI mode
  function automatic logic usp_spi_sel(input logic uart, input logic [2:0] f);
    return !uart && (f <= USP_S_SPI);
  endfunction

  // First bit on the wire for a byte, given the shift order
  function automatic logic usp_out_bit(input logic [7:0] b, input logic msb);
    return msb ? b[7] : b[0];
  endfunction
endpackage

// ---- src/usp_spi_top.sv ----
// SPI function of the shared serial unit: APB registers, master and slave engine.
// Assumes every pin input is synchronous to pclk; pad direction is set by the _oe outputs.
`timescale 1ns/100ps
module usp_spi_top import usp_pkg::*; #(
  parameter int unsigned ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sub_clk,
  input wire logic tmr_match,
  input wire logic int_en,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe,
  input wire logic slave_select_n_i,
  output logic slave_select_n_o,
  output logic slave_select_n_oe,
  output logic irq
);
  // Offsets must fit the address bus
  if (ADDR_W < 4) begin : g_addr_chk
    $error("usp_spi_top: ADDR_W must be at least 4");
  end

  // Register state
  logic [7:0] mode_q;
  logic [7:0] fmt_q;
  logic [7:0] data_q;
  logic [7:0] sh_q;
  usp_state_t st_q;
  usp_state_t st_d;
  logic [4:0] edg_q;
  logic [3:0] cap_q;
  logic sck_q;
  logic sdo_q;
  logic sck_oe_q;
  logic sdo_oe_q;
  logic ss_n_q;
  logic ss_oe_q;
  logic irq_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  // Field views
  logic [2:0] op_mode_field;
  logic uart_select;
  logic interface_enable;
  logic slave_incomplete_flag;
  logic clock_idle_polarity;
  logic capture_edge_select;
  logic shift_order;
  logic select_pin_enable;
  logic write_collision_flag;
  logic transfer_complete_flag;

  assign op_mode_field = mode_q[MODE_FIELD_LSB +: 3];
  assign uart_select = mode_q[MODE_UART_BIT];
  assign interface_enable = mode_q[MODE_EN_BIT];
  assign slave_incomplete_flag = mode_q[MODE_ICF_BIT];
  assign clock_idle_polarity = fmt_q[FMT_POL_BIT];
  assign capture_edge_select = fmt_q[FMT_EDGE_BIT];
  assign shift_order = fmt_q[FMT_MSB_BIT];
  assign select_pin_enable = fmt_q[FMT_SELECT_PIN_ENABLE_BIT];
  assign write_collision_flag = fmt_q[FMT_WRITE_COLLISION_FLAG_BIT];
  assign transfer_complete_flag = fmt_q[FMT_TRF_BIT];

  // Pin edge detectors
  logic sck_lvl;
  logic sck_rise;
  logic sck_fall;
  logic ss_lvl;
  logic ss_rise;
  logic ss_fall;
  logic tick;

  usp_edge #(.RST(1'b1)) u_sck_edge (
    .pclk(pclk),
    .presetn(presetn),
    .d(sck_i),
    .lvl(sck_lvl),
    .rise(sck_rise),
    .fall(sck_fall)
  );

  usp_edge #(.RST(1'b1)) u_ss_edge (
    .pclk(pclk),
    .presetn(presetn),
    .d(slave_select_n_i),
    .lvl(ss_lvl),
    .rise(ss_rise),
    .fall(ss_fall)
  );

  // Master clock only runs during a master transfer
  usp_clk_gen u_clk_gen (
    .pclk(pclk),
    .presetn(presetn),
    .run(st_q == USP_MXFER),
    .sel(op_mode_field),
    .sub_clk(sub_clk),
    .tmr_match(tmr_match),
    .tick(tick)
  );

  // Mode decode
  logic spi_regs;
  logic data_vis;
  logic spi_on;
  logic is_master;
  logic is_slave;
  logic selected;

  always_comb begin
    spi_regs = usp_spi_sel(uart_select, op_mode_field);
    data_vis = spi_regs || (!uart_select && op_mode_field == USP_S_I2C);
    spi_on = interface_enable && usp_spi_sel(uart_select, op_mode_field);
    is_master = spi_on && (op_mode_field <= USP_M_TMR);
    is_slave = spi_on && (op_mode_field == USP_S_SPI);
    selected = !select_pin_enable || !ss_lvl;
  end

  // APB decode; one wait state, writes land when pready is seen high
  logic hit_mode;
  logic hit_fmt;
  logic hit_data;
  logic unmapped;
  logic acc;
  logic setup_acc;
  logic wr_mode;
  logic wr_fmt;
  logic wr_data;
  logic [7:0] rd_mux;

  always_comb begin
    hit_mode = paddr == ADDR_W'(USP_OFF_MODE);
    hit_fmt = (paddr == ADDR_W'(USP_OFF_FMT)) && spi_regs;
    hit_data = (paddr == ADDR_W'(USP_OFF_DATA)) && data_vis;
    unmapped = !(hit_mode || hit_fmt || hit_data);
    acc = psel && penable && pready_q;
    setup_acc = psel && penable && !pready_q;
    wr_mode = acc && pwrite && hit_mode;
    wr_fmt = acc && pwrite && hit_fmt;
    wr_data = acc && pwrite && hit_data;
    rd_mux = 8'h00;
    if (hit_mode) begin
      rd_mux = mode_q;
    end else if (hit_fmt) begin
      rd_mux = fmt_q;
    end else if (hit_data) begin
      rd_mux = data_q;
    end
  end

  // Transfer events
  logic busy;
  logic cap_rise;
  logic slave_ok;
  logic ev_edge;
  logic ev_rise;
  logic ev_cap;
  logic ev_drv;
  logic last_cap;
  logic m_done;
  logic s_done;
  logic early;
  logic hw_trf;
  logic start_m;
  logic data_ok;
  logic collide;
  logic [7:0] rx_byte;

  always_comb begin
    busy = st_q != USP_IDLE;
    // Capture on the rising edge when polarity equals edge select
    cap_rise = !(clock_idle_polarity ^ capture_edge_select);
    slave_ok = is_slave && selected && (st_q != USP_MXFER);
    ev_edge = 1'b0;
    ev_rise = 1'b0;
    if (st_q == USP_MXFER) begin
      ev_edge = tick;
      ev_rise = !sck_q;
    end else if (slave_ok) begin
      ev_edge = sck_rise || sck_fall;
      ev_rise = sck_rise;
    end
    ev_cap = ev_edge && (ev_rise == cap_rise);
    // No drive edge before the first capture: the first bit is preloaded
    ev_drv = ev_edge && !ev_cap && (cap_q != 4'h0);
    last_cap = ev_cap && (cap_q == USP_BITS - 4'h1);
    m_done = (st_q == USP_MXFER) && tick && (edg_q == USP_EDGES - 5'h01);
    s_done = slave_ok && last_cap;
    // Early deselect only counts in slave mode with the select pin in use
    early = is_slave && select_pin_enable && ss_rise && (cap_q != 4'h0);
    hw_trf = m_done || s_done || early;
    start_m = wr_data && !busy && is_master;
    data_ok = wr_data && !busy;
    collide = wr_data && busy;
    if (shift_order) begin
      rx_byte = {sh_q[6:0], sdi_i};
    end else begin
      rx_byte = {sdi_i, sh_q[7:1]};
    end
  end

  // Engine state
  always_comb begin
    st_d = st_q;
    case (st_q)
      USP_IDLE: begin
        if (start_m) begin
          st_d = USP_MXFER;
        end else if (slave_ok && ev_cap && !s_done) begin
          st_d = USP_SXFER;
        end
      end
      USP_MXFER: begin
        if (!is_master || m_done) begin
          st_d = USP_IDLE;
        end
      end
      USP_SXFER: begin
        if (!is_slave || !selected || s_done || early) begin
          st_d = USP_IDLE;
        end
      end
      default: st_d = USP_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= USP_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // Bit and edge counters restart whenever the engine goes idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_q <= 4'h0;
      edg_q <= 5'h00;
    end else begin
      if (st_d == USP_IDLE) begin
        cap_q <= 4'h0;
      end else if (ev_cap) begin
        cap_q <= cap_q + 4'h1;
      end
      if (st_d != USP_MXFER) begin
        edg_q <= 5'h00;
      end else if (tick) begin
        edg_q <= edg_q + 5'h01;
      end
    end
  end

  // Shift register and shared data register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_q <= USP_DATA_RST;
      data_q <= USP_DATA_RST;
    end else begin
      if (data_ok) begin
        sh_q <= pwdata[7:0];
        data_q <= pwdata[7:0];
      end else if (ev_cap) begin
        sh_q <= rx_byte;
        if (last_cap) begin
          data_q <= rx_byte;
        end
      end
    end
  end

  // Serial output bit: preload on write or select, then advance on drive edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sdo_q <= 1'b1;
    end else if (data_ok) begin
      sdo_q <= usp_out_bit(pwdata[7:0], shift_order);
    end else if (is_slave && ss_fall) begin
      sdo_q <= usp_out_bit(sh_q, shift_order);
    end else if (ev_drv) begin
      sdo_q <= usp_out_bit(sh_q, shift_order);
    end
  end

  // Serial clock: toggles per tick in a master transfer, else rests at idle level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_q <= USP_SCK_RST;
    end else if (st_q == USP_MXFER) begin
      if (tick) begin
        sck_q <= ~sck_q;
      end
    end else begin
      sck_q <= ~clock_idle_polarity;
    end
  end

  // Pad drive; a slave never drives the clock, a disabled unit drives nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_oe_q <= 1'b0;
      sdo_oe_q <= 1'b0;
      ss_oe_q <= 1'b0;
      ss_n_q <= 1'b1;
    end else begin
      sck_oe_q <= is_master;
      sdo_oe_q <= is_master || (is_slave && selected);
      ss_oe_q <= is_master && select_pin_enable;
      ss_n_q <= !(st_q == USP_MXFER && select_pin_enable); // rises a cycle after the last clock edge
    end
  end

  // Mode register; enabling the unit leaves every field as it was
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= USP_MODE_RST;
    end else begin
      if (wr_mode) begin
        mode_q[7:1] <= pwdata[7:1];
      end
      // Hardware set wins over a software clear in the same cycle
      if (early) begin
        mode_q[MODE_ICF_BIT] <= 1'b1;
      end else if (wr_mode) begin
        mode_q[MODE_ICF_BIT] <= pwdata[MODE_ICF_BIT];
      end
    end
  end

  // Format register with its two sticky flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fmt_q <= USP_FMT_RST;
    end else begin
      if (wr_fmt) begin
        fmt_q[7:2] <= pwdata[7:2];
      end
      if (collide) begin
        fmt_q[FMT_WRITE_COLLISION_FLAG_BIT] <= 1'b1;
      end else if (wr_fmt) begin
        fmt_q[FMT_WRITE_COLLISION_FLAG_BIT] <= pwdata[FMT_WRITE_COLLISION_FLAG_BIT];
      end
      if (hw_trf) begin
        fmt_q[FMT_TRF_BIT] <= 1'b1;
      end else if (wr_fmt) begin
        fmt_q[FMT_TRF_BIT] <= pwdata[FMT_TRF_BIT];
      end
    end
  end

  // One-cycle request towards the interrupt controller
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= hw_trf && int_en;
    end
  end

  // APB answer: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= setup_acc;
      pslverr_q <= setup_acc && unmapped;
      if (setup_acc && !pwrite) begin
        prdata_q <= {24'h00_0000, rd_mux};
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign sck_o = sck_q;
  assign sck_oe = sck_oe_q;
  assign sdo_o = sdo_q;
  assign sdo_oe = sdo_oe_q;
  assign slave_select_n_o = ss_n_q;
  assign slave_select_n_oe = ss_oe_q;
  assign irq = irq_q;
endmodule // usp_spi_top

// ---- verification/tb.sv ----
// Self-checking bench: register table, master transfer rows, slave early deselect.
// Assumes the peer model and the bound checker are compiled alongside the design.
`timescale 1ns/100ps
module tb import usp_pkg::*; ;
  typedef struct packed {logic w; logic [7:0] a; logic [7:0] d; logic e;} usp_row_t;
  typedef struct packed {logic [7:0] m; logic [7:0] f; logic [7:0] t; logic [7:0] p; logic i;} usp_xfer_t;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, sck_o, sck_oe, sdo_o, sdo_oe, ss_o, ss_oe, irq, sdi;
  logic sub_clk = 1'b0, tmr_match = 1'b0, int_en = 1'b1, sck_tb = 1'b1, ss_tb = 1'b1;
  logic [7:0] ptx = 8'h00, prx, fmt = 8'h00;
  logic [3:0] div_q = 4'h0;
  int fail_count = 0, checked = 0, irqs = 0;
  wire sck = sck_oe ? sck_o : sck_tb;
  wire ss_n = ss_oe ? ss_o : ss_tb;
  usp_row_t regs [17] = '{'{1'b0, 8'h00, 8'hE0, 1'b0}, '{1'b0, 8'h04, 8'h00, 1'b1}, '{1'b0, 8'h08, 8'h00, 1'b1},
    '{1'b1, 8'h00, 8'h02, 1'b0}, '{1'b0, 8'h04, 8'h00, 1'b0}, '{1'b0, 8'h08, 8'h00, 1'b0},
    '{1'b1, 8'h04, 8'hCC, 1'b0}, '{1'b0, 8'h04, 8'hCC, 1'b0}, '{1'b0, 8'h0C, 8'h00, 1'b1},
    '{1'b1, 8'h00, 8'h12, 1'b0}, '{1'b0, 8'h04, 8'h00, 1'b1}, '{1'b1, 8'h00, 8'h00, 1'b0},
    '{1'b0, 8'h04, 8'hCC, 1'b0}, '{1'b1, 8'h00, 8'hC0, 1'b0}, '{1'b0, 8'h08, 8'h00, 1'b0},
    '{1'b1, 8'h00, 8'h02, 1'b0}, '{1'b0, 8'h04, 8'hCC, 1'b0}};
  usp_xfer_t xf [6] = '{'{8'h02, 8'h0C, 8'hA5, 8'h3C, 1'b1}, '{8'h02, 8'h34, 8'h81, 8'h7E, 1'b1},
    '{8'h22, 8'h1C, 8'h5A, 8'hC3, 1'b0}, '{8'h42, 8'h24, 8'h0F, 8'hF0, 1'b1},
    '{8'h62, 8'h0C, 8'h96, 8'h69, 1'b1}, '{8'h82, 8'h2C, 8'h33, 8'hCC, 1'b1}};
  always #20 pclk = ~pclk;
  // Sub clock and timer match pulses, both synchronous to pclk
  always @(posedge pclk) begin
    div_q <= div_q + 4'h1;
    tmr_match <= (div_q[1:0] == 2'h3);
    if (div_q[1:0] == 2'h1) sub_clk <= ~sub_clk;
    if (irq === 1'b1) irqs++;
  end
  usp_spi_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sub_clk(sub_clk),
    .tmr_match(tmr_match), .int_en(int_en), .sck_i(sck), .sck_o(sck_o), .sck_oe(sck_oe), .sdi_i(sdi),
    .sdo_o(sdo_o), .sdo_oe(sdo_oe), .slave_select_n_i(ss_n), .slave_select_n_o(ss_o),
    .slave_select_n_oe(ss_oe), .irq(irq));
  usp_spi_peer peer_u (.sck(sck), .ss_n(ss_n), .pol(fmt[5]), .edg(fmt[4]), .msb(fmt[3]), .mosi(sdo_o),
    .tx(ptx), .miso(sdi), .rx(prx));
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r,
    output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) fail_count++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 8'h00, r, e);
    chk(nm, {24'h000000, x}, r);
    chk({nm, " pslverr"}, {31'h0, xe}, {31'h0, e});
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    int n0;
    int k;
    logic [31:0] r;
    logic e;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (regs[i]) begin
      if (regs[i].w) wr(regs[i].a, regs[i].d);
      else rd("register", regs[i].a, regs[i].d, regs[i].e);
    end
    $display("test registers done");
    foreach (xf[i]) begin
      int_en <= xf[i].i;
      fmt <= xf[i].f;
      ptx <= xf[i].p;
      n0 = irqs;
      wr(USP_OFF_FMT, xf[i].f);
      wr(USP_OFF_MODE, xf[i].m);
      wr(USP_OFF_DATA, xf[i].t);
      wr(USP_OFF_DATA, 8'h55);
      k = 0;
      r = 32'h0;
      while (r[0] !== 1'b1 && k < 300) begin
        apb(1'b0, USP_OFF_FMT, 8'h00, r, e);
        k++;
      end
      chk("flags", {24'h000000, xf[i].f | 8'h03}, r);
      rd("received", USP_OFF_DATA, xf[i].p, 1'b0);
      chk("peer received", {24'h000000, xf[i].t}, {24'h000000, prx});
      chk("irq count", 32'(xf[i].i), 32'(irqs - n0));
    end
    $display("test master rows done");
    fmt <= 8'h04;
    wr(USP_OFF_FMT, 8'h04);
    wr(USP_OFF_MODE, 8'hA2);
    n0 = irqs;
    ss_tb <= 1'b0;
    repeat (4) @(posedge pclk);
    repeat (6) begin
      sck_tb <= ~sck_tb;
      repeat (3) @(posedge pclk);
    end
    ss_tb <= 1'b1;
    repeat (6) @(posedge pclk);
    rd("incomplete", USP_OFF_MODE, 8'hA3, 1'b0);
    rd("slave flags", USP_OFF_FMT, 8'h05, 1'b0);
    chk("slave irq", 32'h1, 32'(irqs - n0));
    wr(USP_OFF_FMT, 8'h04);
    wr(USP_OFF_MODE, 8'hA2);
    wr(USP_OFF_MODE, 8'hA3);
    rd("soft incomplete", USP_OFF_FMT, 8'h04, 1'b0);
    $display("test slave deselect done");
    wr(USP_OFF_MODE, 8'h00);
    repeat (2) @(posedge pclk);
    chk("drive off", 32'h0, {29'h0, sck_oe, sdo_oe, ss_oe});
    $display("test disable done");
    conclude();
  end
  // Watchdog well beyond the expected run length
  initial begin
    repeat (40000) @(posedge pclk);
    fail_count++;
    conclude();
  end
endmodule // tb

// ---- verification/usp_spi_peer.sv ----
// Behavioural far-side SPI slave used against the block in master mode.
// Assumes one select line frames each byte and the clock stands still between frames.
`timescale 1ns/100ps
module usp_spi_peer (
  input wire logic sck,
  input wire logic ss_n,
  input wire logic pol,
  input wire logic edg,
  input wire logic msb,
  input wire logic mosi,
  input wire logic [7:0] tx,
  output logic miso,
  output logic [7:0] rx
);
  logic [7:0] sh = 8'h00;
  logic [3:0] n = 4'h0;
  logic last = 1'b0;
  // Follows the master's clock only; shifts out only after the first capture
  always @(sck) begin
    if (!ss_n && (sck == (pol == edg))) begin
      rx = msb ? {rx[6:0], mosi} : {mosi, rx[7:1]};
      n = n + 4'h1;
    end else if (!ss_n && n != 4'h0) begin
      sh = msb ? {sh[6:0], 1'b0} : {1'b0, sh[7:1]};
    end
  end
  // Single select: loads the reply on fall, remembers the line on rise
  always @(ss_n) begin
    if (!ss_n) begin
      sh = tx;
      n = 4'h0;
    end else begin
      last = msb ? sh[7] : sh[0];
    end
  end
  // Released line shows the inverse so a stale sample cannot pass
  assign miso = ss_n ? ~last : (msb ? sh[7] : sh[0]);
endmodule // usp_spi_peer

// ---- verification/usp_spi_props.sv ----
// Checker for the SPI block top: APB visibility, pin drive and frame shape.
// Assumes it sees only the top's ports and shadows software writes itself.
`timescale 1ns/100ps
module usp_spi_props import usp_pkg::*; #(
  parameter int unsigned ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sub_clk,
  input wire logic tmr_match,
  input wire logic int_en,
  input wire logic sck_i,
  input wire logic sck_o,
  input wire logic sck_oe,
  input wire logic sdi_i,
  input wire logic sdo_o,
  input wire logic sdo_oe,
  input wire logic slave_select_n_i,
  input wire logic slave_select_n_o,
  input wire logic slave_select_n_oe,
  input wire logic irq
);
  logic [7:0] mode_q;
  logic [7:0] fmt_q;
  logic [7:0] data_q;
  logic [4:0] cnt_q;
  logic sck_p_q;
  logic ss_p_q;
  logic wr_ok;
  logic spi_sel;
  assign wr_ok = psel && penable && pwrite && pready && !pslverr;
  assign spi_sel = !mode_q[MODE_UART_BIT] && (mode_q[7:5] <= 3'h5);
  // Shadows of software writes; hardware-set flags are not tracked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= USP_MODE_RST;
      fmt_q <= USP_FMT_RST;
      data_q <= USP_DATA_RST;
    end else if (wr_ok) begin
      if (paddr == ADDR_W'(USP_OFF_MODE)) mode_q <= pwdata[7:0];
      if (paddr == ADDR_W'(USP_OFF_FMT)) fmt_q <= pwdata[7:0];
      if (paddr == ADDR_W'(USP_OFF_DATA)) data_q <= pwdata[7:0];
    end
  end
  // Clock toggles inside one master frame; cleared once select has been high two cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_p_q <= USP_SCK_RST;
      ss_p_q <= 1'b1;
      cnt_q <= 5'h00;
    end else begin
      sck_p_q <= sck_o;
      ss_p_q <= slave_select_n_o;
      if (slave_select_n_o && ss_p_q) cnt_q <= 5'h00;
      else if (sck_o != sck_p_q) cnt_q <= cnt_q + 5'h01;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_OFF_NO_DRIVE: assert property (!mode_q[MODE_EN_BIT] [*2] |-> !sck_oe && !sdo_oe && !slave_select_n_oe)
    else $error("pins driven while interface off");
  AST_SLAVE_NO_CLK: assert property ((mode_q[MODE_UART_BIT] || mode_q[7:5] == 3'h5) [*2] |-> !sck_oe)
    else $error("clock driven outside master mode");
  AST_IDLE_LEVEL: assert property ((sck_oe && slave_select_n_oe && slave_select_n_o) [*2] ##0 $stable(fmt_q)
    |-> sck_o == !fmt_q[FMT_POL_BIT]) else $error("idle clock level wrong");
  AST_IRQ_GATED: assert property (irq |-> $past(int_en))
    else $error("irq while interrupt disabled");
  AST_IRQ_PULSE: assert property (irq |=> !irq)
    else $error("irq longer than one cycle");
  AST_EIGHT_BITS: assert property ($rose(slave_select_n_o) |=> cnt_q == USP_EDGES)
    else $error("frame clock edge count wrong");
  AST_FIRST_BIT: assert property ($fell(slave_select_n_o)
    |-> sdo_oe && sdo_o == (fmt_q[FMT_MSB_BIT] ? data_q[7] : data_q[0])) else $error("first data bit wrong");
  AST_HIDDEN_FMT: assert property (pready && psel && paddr == ADDR_W'(USP_OFF_FMT) && !spi_sel |-> pslverr)
    else $error("format register visible outside SPI mode");
  AST_MASTER_CLK: assert property (!slave_select_n_o |-> slave_select_n_oe && sck_oe)
    else $error("frame without master clock drive");
  cover property ($rose(slave_select_n_o));
  cover property (irq);
  cover property (pslverr);
  cover property (mode_q[7:5] == 3'h5 && $rose(slave_select_n_i));
endmodule // usp_spi_props
bind usp_spi_top usp_spi_props #(.ADDR_W(ADDR_W)) props_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sub_clk(sub_clk), .tmr_match(tmr_match), .int_en(int_en), .sck_i(sck_i), .sck_o(sck_o),
  .sck_oe(sck_oe), .sdi_i(sdi_i), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .slave_select_n_i(slave_select_n_i),
  .slave_select_n_o(slave_select_n_o), .slave_select_n_oe(slave_select_n_oe), .irq(irq));
